// >>> hw/link_core_end.sv
`timescale 1ns/1ps
`default_nettype none
module link_core_end
  import user_port_pkg::*;
#(
  parameter int LANES      = LANE_COUNT,
  parameter int LANE_BYTES = BYTES_PER_LANE,
  parameter bit FRAMING    = FRAMING_MODE,
  parameter bit HAS_TX     = TX_ENABLED,
  parameter bit HAS_RX     = RX_ENABLED,
  parameter int N_BYTES    = LANES * LANE_BYTES
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic         clk_en_i,
  user_port_if.core_end     port,
  // link side: outgoing words to the serialiser
  input  wire logic         link_tx_ready_i,
  output logic [0:8*N_BYTES-1] link_tx_data_o,
  output logic [0:N_BYTES-1]   link_tx_qualifier_o,
  output logic              link_tx_frame_end_o,
  output logic              link_tx_valid_o,
  output logic              tx_keep_error_o,
  // link side: incoming words from the deserialiser
  input  wire logic [0:8*N_BYTES-1] link_rx_data_i,
  input  wire logic [0:N_BYTES-1]   link_rx_qualifier_i,
  input  wire logic         link_rx_frame_end_i,
  input  wire logic         link_rx_valid_i
);
  localparam logic [0:N_BYTES-1] ALL_BYTES = '1;

  // accept flag: one-word holding stage drains into the link
  // one-hot codes: each state is a single flop, but hold_full compares both bits
  typedef enum logic [1:0]
  {
    HOLD_EMPTY = 2'h1,
    HOLD_FULL  = 2'h2
  } hold_state_e;

  hold_state_e      hold_state;
  hold_state_e      next_hold_state;
  logic             hold_full;
  logic             tx_end_used;
  logic             take_word;
  logic             drain_word;
  logic             contiguous;
  logic [0:N_BYTES-1] tx_qual_used;

  assign drain_word = hold_full & link_tx_ready_i;
  assign port.tx_accept_flag = HAS_TX & clk_en_i & (~hold_full | link_tx_ready_i);
  assign take_word  = port.tx_accept_flag & port.tx_word_present;
  // qualifier only meaningful on the last beat; others carry all bytes
  assign tx_qual_used = (FRAMING && port.tx_frame_end) ? port.tx_byte_qualifier
                                                       : ALL_BYTES;

  keep_checker #(
    .N_BYTES (N_BYTES)
  ) u_tx_keep (
    .qualifier_i  (tx_qual_used),
    .contiguous_o (contiguous),
    .count_o      ()
  );

  // frame end only exists in framing builds
  assign tx_end_used = FRAMING & port.tx_frame_end;

  // next state: a take refills the stage even while it drains
  always_comb
  begin
    next_hold_state = hold_state;
    case (hold_state)
      HOLD_EMPTY:
      begin
        if (take_word)
        begin
          next_hold_state = HOLD_FULL;
        end
      end
      HOLD_FULL:
      begin
        if (drain_word && !take_word)
        begin
          next_hold_state = HOLD_EMPTY;
        end
      end
      default:
      begin
        next_hold_state = HOLD_EMPTY;
      end
    endcase
  end
  assign hold_full = (hold_state == HOLD_FULL);

  // stage state; frozen with the clock enable like every other flop
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      hold_state <= HOLD_EMPTY;
    end
    else if (clk_en_i)
    begin
      hold_state <= next_hold_state;
    end
  end

  // transmit holding register; loads only on a take
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      link_tx_data_o      <= '0;
      link_tx_qualifier_o <= '0;
      link_tx_frame_end_o <= RST_LEVEL;
      tx_keep_error_o     <= RST_LEVEL;
    end
    else if (clk_en_i && take_word)
    begin
      link_tx_data_o      <= port.tx_data;
      link_tx_qualifier_o <= tx_qual_used;
      link_tx_frame_end_o <= tx_end_used;
      tx_keep_error_o     <= ~contiguous;
    end
  end
  assign link_tx_valid_o = hold_full;

  // receive register; no back-pressure, sink must take every word
  logic             rx_present;
  logic             rx_end;
  logic [0:N_BYTES-1]   rx_qual;
  logic [0:8*N_BYTES-1] rx_word;
  logic             rx_take;
  logic             rx_end_next;
  logic [0:N_BYTES-1]   rx_qual_next;

  // a word only counts in a receive build; frame end only with a word
  assign rx_take     = HAS_RX & link_rx_valid_i;
  assign rx_end_next = FRAMING & rx_take & link_rx_frame_end_i;

  // per byte: a qualifier bit survives only on a valid final beat
  genvar b;
  generate
    for (b = 0; b < N_BYTES; b++)
    begin : g_rx_qual
      assign rx_qual_next[b] = rx_end_next & link_rx_qualifier_i[b];
    end
  endgenerate

  // received word and its sideband, one cycle per word
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rx_present <= RST_LEVEL;
      rx_end     <= RST_LEVEL;
      rx_qual    <= '0;
      rx_word    <= '0;
    end
    else if (clk_en_i)
    begin
      rx_present <= rx_take;
      // frame end rides one word, so it lasts one cycle
      rx_end     <= rx_end_next;
      rx_qual    <= rx_qual_next;
      if (rx_take)
      begin
        rx_word <= link_rx_data_i;
      end
    end
  end

  // streaming or simplex builds tie the unused outputs low, not remove them
  generate
    if (HAS_RX)
    begin : g_rx_on
      assign port.rx_word_present   = rx_present & clk_en_i;
      assign port.rx_data           = rx_word;
    end
    else
    begin : g_rx_off
      assign port.rx_word_present   = 1'h0;
      assign port.rx_data           = '0;
    end
    if (FRAMING)
    begin : g_framed
      assign port.rx_frame_end      = rx_end & clk_en_i;
      assign port.rx_byte_qualifier = rx_qual;
    end
    else
    begin : g_streamed
      assign port.rx_frame_end      = 1'h0;
      assign port.rx_byte_qualifier = '0;
    end
  endgenerate
endmodule // link_core_end
`default_nettype wire

// >>> hw/user_port_pkg.sv
`default_nettype none
package user_port_pkg;
  // lane geometry: bytes per word is lanes times bytes per lane
  localparam int LANE_COUNT     = 1;
  localparam int BYTES_PER_LANE = 2;
  localparam int WORD_BYTES     = LANE_COUNT * BYTES_PER_LANE;
  localparam int BITS_PER_BYTE  = 8;
  localparam int WORD_BITS      = BITS_PER_BYTE * WORD_BYTES;
  // build options
  localparam bit FRAMING_MODE   = 1'h1;
  localparam bit TX_ENABLED     = 1'h1;
  localparam bit RX_ENABLED     = 1'h1;
  // reset values
  localparam logic RST_LEVEL    = 1'h0;
  localparam logic RST_ACCEPT   = 1'h0;
endpackage : user_port_pkg
`default_nettype wire

// >>> hw/user_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface user_port_if
  import user_port_pkg::*;
#(
  parameter int N_BYTES = WORD_BYTES
);
  logic [0:8*N_BYTES-1] tx_data;
  logic                 tx_word_present;
  logic                 tx_accept_flag;
  logic                 tx_frame_end;
  logic [0:N_BYTES-1]   tx_byte_qualifier;
  logic [0:8*N_BYTES-1] rx_data;
  logic                 rx_word_present;
  logic                 rx_frame_end;
  logic [0:N_BYTES-1]   rx_byte_qualifier;

  // the core end: sinks transmit words, sources received words
  modport core_end
  (
    input  tx_data, tx_word_present, tx_frame_end, tx_byte_qualifier,
    output tx_accept_flag,
    output rx_data, rx_word_present, rx_frame_end, rx_byte_qualifier
  );
  // the user application end
  modport app_end
  (
    output tx_data, tx_word_present, tx_frame_end, tx_byte_qualifier,
    input  tx_accept_flag,
    input  rx_data, rx_word_present, rx_frame_end, rx_byte_qualifier
  );
endinterface : user_port_if
`default_nettype wire

// >>> hw/keep_checker.sv
`timescale 1ns/1ps
`default_nettype none
// flags a byte qualifier that is not a contiguous run from byte 0
module keep_checker
  import user_port_pkg::*;
#(
  parameter int N_BYTES = WORD_BYTES
)
(
  input  wire logic [0:N_BYTES-1] qualifier_i,
  output logic                    contiguous_o,
  output logic [$clog2(N_BYTES+1)-1:0] count_o
);
  logic [N_BYTES-1:0] gap;
  logic [N_BYTES-1:0] bit_valid;
  genvar g;
  // a set byte after a clear byte is a gap
  generate
    for (g = 0; g < N_BYTES; g++)
    begin : g_byte
      assign bit_valid[g] = qualifier_i[g];
      if (g == 0)
      begin : g_first
        assign gap[g] = 1'b0;
      end
      else
      begin : g_rest
        assign gap[g] = qualifier_i[g] & ~qualifier_i[g-1];
      end
    end
  endgenerate
  assign contiguous_o = ~|gap;
  // cast through a local width so the count is sized on purpose
  localparam int CNT_W = $clog2(N_BYTES + 1);
  assign count_o      = CNT_W'($countones(bit_valid));
endmodule // keep_checker
`default_nettype wire

// >>> hw/link_app_end.sv
`timescale 1ns/1ps
`default_nettype none
// user application end: offers words, holds them until taken, captures all
module link_app_end
  import user_port_pkg::*;
#(
  parameter int N_BYTES = WORD_BYTES,
  parameter bit FRAMING = FRAMING_MODE
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic         clk_en_i,
  user_port_if.app_end      port,
  // user request: a word to send
  input  wire logic         send_valid_i,
  input  wire logic [0:8*N_BYTES-1] send_data_i,
  input  wire logic         send_last_i,
  input  wire logic [0:N_BYTES-1]   send_qualifier_i,
  output logic              send_ready_o,
  // received words, one-cycle strobe with registered data
  output logic              recv_strobe_o,
  output logic [0:8*N_BYTES-1] recv_data_o,
  output logic              recv_last_o,
  output logic [0:N_BYTES-1]   recv_qualifier_o
);
  logic             pend;
  logic [0:8*N_BYTES-1] pend_data;
  logic             pend_last;
  logic [0:N_BYTES-1]   pend_qual;
  logic             taken;
  logic             load;
  // middle beats offer every byte; the qualifier only counts at the end
  localparam logic [0:N_BYTES-1] ALL_BYTES = '1;

  assign taken        = pend & port.tx_accept_flag;
  assign send_ready_o = clk_en_i & (~pend | taken);
  assign load         = send_ready_o & send_valid_i;

  // offered word stays put until accepted
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pend      <= RST_LEVEL;
      pend_data <= '0;
      pend_last <= RST_LEVEL;
      pend_qual <= '0;
    end
    else if (clk_en_i)
    begin
      if (load)
      begin
        pend      <= 1'b1;
        pend_data <= send_data_i;
        pend_last <= FRAMING & send_last_i;
        pend_qual <= (FRAMING && send_last_i) ? send_qualifier_i : ALL_BYTES;
      end
      else if (taken)
      begin
        pend <= 1'b0;
      end
    end
  end

  assign port.tx_word_present   = pend;
  assign port.tx_data           = pend_data;
  assign port.tx_frame_end      = pend_last;
  assign port.tx_byte_qualifier = pend_qual;

  // capture every presented word; the core cannot wait
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      recv_strobe_o    <= RST_LEVEL;
      recv_data_o      <= '0;
      recv_last_o      <= RST_LEVEL;
      recv_qualifier_o <= '0;
    end
    else if (clk_en_i)
    begin
      recv_strobe_o <= port.rx_word_present;
      recv_last_o   <= port.rx_word_present & port.rx_frame_end;
      if (port.rx_word_present)
      begin
        recv_data_o      <= port.rx_data;
        recv_qualifier_o <= port.rx_frame_end ? port.rx_byte_qualifier : '0;
      end
    end
  end
endmodule // link_app_end
`default_nettype wire

// >>> dv/user_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches the user port where both ends meet
module user_port_assertions
  import user_port_pkg::*;
#(
  parameter int N_BYTES = WORD_BYTES
)
(
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic [0:8*N_BYTES-1] tx_data,
  input wire logic                 tx_word_present,
  input wire logic                 tx_accept_flag,
  input wire logic                 tx_frame_end,
  input wire logic [0:N_BYTES-1]   tx_byte_qualifier,
  input wire logic                 rx_word_present,
  input wire logic                 rx_frame_end,
  input wire logic [0:N_BYTES-1]   rx_byte_qualifier
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // offered word refused, then the same word again
  sequence s_stall;
    tx_word_present && !tx_accept_flag;
  endsequence
  sequence s_held;
    $stable(tx_data) && $stable(tx_frame_end);
  endsequence
  chk_hold_word: assert property (s_stall |=> s_held)
    else $error("tx word changed while refused");
  chk_hold_qual: assert property (s_stall |=> $stable(tx_byte_qualifier))
    else $error("tx qualifier changed while refused");
  chk_still_offered: assert property (s_stall |=> tx_word_present)
    else $error("tx word withdrawn before accept");
  // back-to-back one-word frames are legal, so only a lone end must drop
  sequence s_rx_last;
    rx_frame_end && rx_word_present;
  endsequence
  sequence s_rx_mid;
    rx_word_present && !rx_frame_end;
  endsequence
  chk_rx_end_pulse: assert property (s_rx_last ##1 !rx_word_present |-> !rx_frame_end)
    else $error("rx frame end longer than one cycle");
  chk_rx_keep_idle: assert property (s_rx_mid |-> !(|rx_byte_qualifier))
    else $error("rx qualifier set off the final beat");
  chk_end_with_word: assert property (rx_frame_end |-> rx_word_present)
    else $error("rx frame end without word");
  chk_rx_keep_low: assert property (rx_frame_end |-> rx_byte_qualifier[0])
    else $error("rx final beat lacks byte zero");
  chk_tx_keep_full: assert property (tx_word_present && !tx_frame_end |-> &tx_byte_qualifier)
    else $error("tx qualifier not full mid frame");
endmodule // user_port_assertions
`default_nettype wire

// >>> dv/serial_link_user_data_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_user_data_port_test;
  import user_port_pkg::*;
  localparam int W = WORD_BITS + WORD_BYTES + 1;
  logic clk_sys_i, rst_n_i, ready, s_valid, s_last, s_rdy, l_valid, l_end;
  logic l_tx_valid, l_tx_end, keep_err, r_strobe, r_last, clk_en;
  logic [0:WORD_BITS-1] s_data, l_data, l_tx_data, r_data;
  logic [0:WORD_BYTES-1] s_qual, l_qual, l_tx_qual, r_qual;
  logic [W-1:0] txq[$], rxq[$];
  int failures, n_checks, cyc;
  user_port_if u_if ();
  link_core_end u_link_core_end (.clk_sys_i, .rst_n_i, .clk_en_i(clk_en), .port(u_if.core_end),
    .link_tx_ready_i(ready), .link_tx_data_o(l_tx_data), .link_tx_qualifier_o(l_tx_qual),
    .link_tx_frame_end_o(l_tx_end), .link_tx_valid_o(l_tx_valid), .tx_keep_error_o(keep_err),
    .link_rx_data_i(l_data), .link_rx_qualifier_i(l_qual), .link_rx_frame_end_i(l_end),
    .link_rx_valid_i(l_valid));
  link_app_end u_link_app_end (.clk_sys_i, .rst_n_i, .clk_en_i(clk_en), .port(u_if.app_end),
    .send_valid_i(s_valid), .send_data_i(s_data), .send_last_i(s_last),
    .send_qualifier_i(s_qual), .send_ready_o(s_rdy), .recv_strobe_o(r_strobe),
    .recv_data_o(r_data), .recv_last_o(r_last), .recv_qualifier_o(r_qual));
  user_port_assertions #(.N_BYTES(WORD_BYTES)) u_chk (.clk_sys_i, .rst_n_i,
    .tx_data(u_if.tx_data), .tx_word_present(u_if.tx_word_present),
    .tx_accept_flag(u_if.tx_accept_flag), .tx_frame_end(u_if.tx_frame_end),
    .tx_byte_qualifier(u_if.tx_byte_qualifier), .rx_word_present(u_if.rx_word_present),
    .rx_frame_end(u_if.rx_frame_end), .rx_byte_qualifier(u_if.rx_byte_qualifier));
  initial
  begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // log words leaving on the link and reaching the user; cut a hang short
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (l_tx_valid && ready) txq.push_back({l_tx_data, l_tx_qual, l_tx_end});
    if (r_strobe) rxq.push_back({r_data, r_qual, r_last});
    if (cyc == 3000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // leaves valid high so words can follow back to back
  task automatic send(logic [0:WORD_BITS-1] d, logic last, logic [0:WORD_BYTES-1] q);
    s_data = d;
    s_last = last;
    s_qual = q;
    s_valid = 1;
    #1;
    // look after the falling edge settles, so a same-edge ready change is seen
    while (!s_rdy)
    begin
      @(negedge clk_sys_i);
      #1;
    end
    @(negedge clk_sys_i);
  endtask
  task automatic t_keep();
    ready = 1;
    send(16'h00ab, 1, 2'b01);
    s_valid = 0;
    repeat (4) @(negedge clk_sys_i);
    check("keep error", keep_err, 1);
    txq.delete();
    $display("t_keep done");
  endtask
  task automatic t_tx();
    logic [W-1:0] exp [3];
    exp = '{{16'h1234, 2'b11, 1'b0}, {16'h5678, 2'b11, 1'b0}, {16'h9a00, 2'b10, 1'b1}};
    ready = 0;
    fork
      begin
        send(16'h1234, 0, 2'b11);
        send(16'h5678, 0, 2'b11);
        send(16'h9a00, 1, 2'b10);
        s_valid = 0;
      end
      begin
        repeat (8) @(negedge clk_sys_i);
        ready = 1;
      end
    join
    repeat (6) @(negedge clk_sys_i);
    check("tx count", txq.size(), 3);
    foreach (exp[i]) check("tx word", txq.pop_front(), exp[i]);
    check("keep clear", keep_err, 0);
    $display("t_tx done");
  endtask
  task automatic t_rx();
    l_valid = 1;
    l_data = 16'hc0de;
    @(negedge clk_sys_i);
    l_data = 16'hbeef;
    l_end = 1;
    l_qual = 2'b10;
    @(negedge clk_sys_i);
    l_valid = 0;
    l_end = 0;
    l_data = 16'h4110;
    l_qual = 2'b01;
    repeat (5) @(negedge clk_sys_i);
    check("rx count", rxq.size(), 2);
    check("rx word", rxq.pop_front(), {16'hc0de, 2'b00, 1'b0});
    check("rx last", rxq.pop_front(), {16'hbeef, 2'b10, 1'b1});
    $display("t_rx done");
  endtask
  // clock enable low: nothing moves on either end until it returns
  task automatic t_freeze();
    clk_en = 0;
    {s_valid, s_last, l_valid, l_end} = 4'hf;
    {s_data, l_data} = {16'h0f0f, 16'h0f0f};
    {s_qual, l_qual} = 4'hf;
    repeat (3) @(negedge clk_sys_i);
    check("frozen accept", u_if.tx_accept_flag, 0);
    check("frozen words", rxq.size() + txq.size(), 0);
    clk_en = 1;
    @(negedge clk_sys_i);
    {s_valid, l_valid, l_end} = '0;
    repeat (3) @(negedge clk_sys_i);
    check("thawed tx", txq.pop_front(), {16'h0f0f, 2'b11, 1'b1});
    check("thawed rx", rxq.pop_front(), {16'h0f0f, 2'b11, 1'b1});
    $display("t_freeze done");
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, ready, s_valid, s_last, l_valid, l_end} = '0;
    clk_en = 1;
    {s_data, s_qual, l_data, l_qual} = '0;
    {failures, n_checks, cyc} = '0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1;
    t_keep();
    t_tx();
    t_rx();
    t_freeze();
    complete_run();
  end
endmodule // serial_link_user_data_port_test
`default_nettype wire
